// ===== hw/xsk_decode.sv
// Decode and execute of test-skip, XOR and extended instruction group.
// Assumes file read data arrive combinationally for fdata_addr in the same cycle.
`timescale 1ns/100ps
// How it works
// - Test-skip-if-zero decoded from 0110 011a plus file address.
// - Zero file value discards the fetched word; instruction takes two cycles.
// - Skipping a two-word instruction costs three cycles in total.
// - Access bit 0 uses direct bank, 1 uses bank select pointer.
// - Access 0, extension on, address at most 95 uses indexed frame offset.
// - XOR literal, 0000 1010, writes accumulator xor literal to accumulator.
// - XOR file, 0001 10da; destination 0 accumulator, 1 file.
// - Both XOR forms update only N and Z; file form takes one cycle.
// - Extended instructions and indexed addressing off unless enable fuse set.
// - Pointer add/subtract use 2-bit select and 6-bit literal, one cycle for selects 00 to 10.
// - Select 11 adjusts frame pointer and returns, two cycles.
// - Call via accumulator is word 0x0014, two cycles, no flags.
// - Indexed-to-file move is two words, second 1111 plus file address.
// - Push literal stores at frame pointer then decrements it, one cycle.
// - Call pushes next address, loads counter from accumulator and latches.
// - Returning pointer forms reload counter from return stack top.
module xsk_decode (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        extension_enable_fuse,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word,
  input  wire logic [15:0] next_word,
  input  wire logic [7:0]  fdata_rdata,
  input  wire logic [3:0]  bank_select_pointer,
  input  wire logic [7:0]  counter_high_latch,
  input  wire logic [7:0]  counter_upper_latch,
  input  wire logic [20:0] return_stack_top,
  input  wire logic [20:0] pc_in,
  output logic             busy,
  output logic [11:0]      fdata_addr,
  output logic             fdata_we,
  output logic [11:0]      fdata_waddr,
  output logic [7:0]       fdata_wdata,
  output logic [7:0]       acc,
  output logic             flag_n,
  output logic             flag_z,
  output logic             pc_load,
  output logic [20:0]      pc_value,
  output logic             stack_push,
  output logic [20:0]      stack_push_value,
  output logic             stack_pop,
  output logic [11:0]      ptr0,
  output logic [11:0]      ptr1,
  output logic [11:0]      stack_frame_pointer
);
  logic [7:0]  op_hi;
  logic [7:0]  f_addr;
  logic        ext_on;
  logic        is_test_skip;
  logic        is_xor_lit;
  logic        is_xor_file;
  logic        is_add_ptr;
  logic        is_sub_ptr;
  logic        is_push_lit;
  logic        is_move_idx;
  logic        is_call_acc;
  logic        next_is_two_word;
  logic [1:0]  stall_reg;
  logic [7:0]  xor_res;
  logic        ptr_we;
  logic [1:0]  ptr_sel;
  logic [11:0] ptr_wdata;
  logic [11:0] ptr_cur;
  logic        start;

  assign op_hi  = instr_word[15:8];
  assign f_addr = instr_word[7:0];
  assign ext_on = extension_enable_fuse;
  assign start  = instr_valid && (stall_reg == 2'h0);
  assign busy   = (stall_reg != 2'h0);

  assign is_test_skip = (instr_word[15:9] == xsk_pkg::OP_TEST_SKIP);
  assign is_xor_lit   = (op_hi == xsk_pkg::OP_XOR_LIT);
  assign is_xor_file  = (instr_word[15:10] == xsk_pkg::OP_XOR_FILE);
  assign is_add_ptr   = ext_on && (op_hi == xsk_pkg::OP_ADD_PTR);
  assign is_sub_ptr   = ext_on && (op_hi == xsk_pkg::OP_SUB_PTR);
  assign is_push_lit  = ext_on && (op_hi == xsk_pkg::OP_PUSH_LIT);
  assign is_move_idx  = ext_on && (op_hi == xsk_pkg::OP_MOVE_IDX);
  assign is_call_acc  = ext_on && (instr_word == xsk_pkg::OP_CALL_ACC);

  // A following word that is the head of a two-word form costs an extra skip cycle.
  assign next_is_two_word = ext_on && (next_word[15:8] == xsk_pkg::OP_MOVE_IDX);

  // Address of the byte-oriented operand.
  // Moves read their source at the frame pointer plus the 7-bit offset of the first word.
  always_comb begin
    if (is_move_idx) begin
      fdata_addr = stack_frame_pointer + {5'h00, instr_word[6:0]};
    end else if (!instr_word[xsk_pkg::ACCESS_BIT] && ext_on && f_addr <= xsk_pkg::INDEX_LIMIT) begin
      fdata_addr = stack_frame_pointer + {4'h0, f_addr};
    end else if (!instr_word[xsk_pkg::ACCESS_BIT]) begin
      fdata_addr = {4'h0, f_addr};
    end else begin
      fdata_addr = {bank_select_pointer, f_addr};
    end
  end

  assign xor_res = acc ^ (is_xor_lit ? f_addr : fdata_rdata);

  // Multi-cycle instructions hold busy; the extra cycles are no-operations.
  always_ff @(posedge mclk) begin
    if (rst) begin
      stall_reg <= 2'h0;
    end else if (stall_reg != 2'h0) begin
      stall_reg <= stall_reg - 2'h1;
    end else if (start && is_test_skip && fdata_rdata == 8'h00) begin
      stall_reg <= next_is_two_word ? xsk_pkg::CYC_TWO : xsk_pkg::CYC_ONE;
    end else if (start && (is_add_ptr || is_sub_ptr) && instr_word[7:6] == xsk_pkg::FRAME_SEL) begin
      stall_reg <= xsk_pkg::CYC_ONE;
    end else if (start && (is_call_acc || is_move_idx)) begin
      stall_reg <= xsk_pkg::CYC_ONE;
    end
  end

  // Accumulator and N, Z flags; no other instruction here touches flags.
  always_ff @(posedge mclk) begin
    if (rst) begin
      acc    <= xsk_pkg::ACC_RESET;
      flag_n <= 1'b0;
      flag_z <= 1'b0;
    end else if (start && (is_xor_lit || is_xor_file)) begin
      flag_n <= xor_res[7];
      flag_z <= (xor_res == 8'h00);
      if (is_xor_lit || !instr_word[xsk_pkg::DEST_BIT]) begin
        acc <= xor_res;
      end
    end
  end

  // Data file writes: XOR to file, push literal, and second word of moves.
  always_ff @(posedge mclk) begin
    if (rst) begin
      fdata_we    <= 1'b0;
      fdata_waddr <= 12'h000;
      fdata_wdata <= 8'h00;
    end else begin
      fdata_we <= 1'b0;
      if (start && is_xor_file && instr_word[xsk_pkg::DEST_BIT]) begin
        fdata_we    <= 1'b1;
        fdata_waddr <= fdata_addr;
        fdata_wdata <= xor_res;
      end else if (start && is_push_lit) begin
        fdata_we    <= 1'b1;
        fdata_waddr <= stack_frame_pointer;
        fdata_wdata <= f_addr;
      end else if (start && is_move_idx && next_word[15:12] == xsk_pkg::OP_SECOND) begin
        fdata_we    <= 1'b1;
        fdata_waddr <= instr_word[xsk_pkg::MOVE_KIND_BIT] ?
                       stack_frame_pointer + {5'h00, next_word[6:0]} : next_word[11:0];
        fdata_wdata <= fdata_rdata;
      end
    end
  end

  // Pointer updates for add, subtract and push.
  always_comb begin
    ptr_sel = (is_push_lit || instr_word[7:6] == xsk_pkg::FRAME_SEL) ? 2'h2 : instr_word[7:6];
    case (ptr_sel)
      2'h0:    ptr_cur = ptr0;
      2'h1:    ptr_cur = ptr1;
      default: ptr_cur = stack_frame_pointer;
    endcase
    ptr_we    = start && (is_add_ptr || is_sub_ptr || is_push_lit);
    if (is_push_lit) begin
      ptr_wdata = ptr_cur - 12'h001;
    end else if (is_add_ptr) begin
      ptr_wdata = ptr_cur + {6'h00, instr_word[5:0]};
    end else begin
      ptr_wdata = ptr_cur - {6'h00, instr_word[5:0]};
    end
  end

  xsk_ptr_file #(.W(12)) u_ptrs (
    .mclk  (mclk),
    .rst   (rst),
    .we    (ptr_we),
    .wsel  (ptr_sel),
    .wdata (ptr_wdata),
    .ptr0  (ptr0),
    .ptr1  (ptr1),
    .ptr2  (stack_frame_pointer)
  );

  // Program counter and return stack; a lone 1111 word falls through as no-op.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pc_load          <= 1'b0;
      pc_value         <= xsk_pkg::PC_RESET;
      stack_push       <= 1'b0;
      stack_push_value <= xsk_pkg::PC_RESET;
      stack_pop        <= 1'b0;
    end else begin
      pc_load    <= 1'b0;
      stack_push <= 1'b0;
      stack_pop  <= 1'b0;
      if (start && is_call_acc) begin
        stack_push       <= 1'b1;
        stack_push_value <= pc_in + 21'h00_0002;
        pc_load          <= 1'b1;
        pc_value         <= {counter_upper_latch[4:0], counter_high_latch, acc};
      end else if (start && (is_add_ptr || is_sub_ptr) && instr_word[7:6] == xsk_pkg::FRAME_SEL) begin
        pc_load   <= 1'b1;
        pc_value  <= return_stack_top;
        stack_pop <= 1'b1;
      end
    end
  end

  a_xor_flags_only: assert property (@(posedge mclk) disable iff (rst)
    (start && !is_xor_lit && !is_xor_file) |=> $stable(flag_n) && $stable(flag_z))
    else $error("flags changed outside xor");
  a_xor_lit_result: assert property (@(posedge mclk) disable iff (rst)
    (start && is_xor_lit) |=> acc == ($past(acc) ^ $past(f_addr)))
    else $error("xor literal result wrong");
  a_xor_to_acc: assert property (@(posedge mclk) disable iff (rst)
    (start && is_xor_file && !instr_word[9]) |=> !fdata_we && acc == ($past(acc) ^ $past(fdata_rdata)))
    else $error("xor to accumulator wrong");
  a_skip_two_cyc: assert property (@(posedge mclk) disable iff (rst)
    (start && is_test_skip && fdata_rdata == 8'h00 && !next_is_two_word) |=> busy ##1 !busy)
    else $error("skip length wrong");
  a_skip_three_cyc: assert property (@(posedge mclk) disable iff (rst)
    (start && is_test_skip && fdata_rdata == 8'h00 && next_is_two_word) |=> busy [*2] ##1 !busy)
    else $error("two word skip length wrong");
  a_no_ext_off: assert property (@(posedge mclk) disable iff (rst)
    !extension_enable_fuse |=> !pc_load && !stack_push)
    else $error("extension acted while off");
  a_ptr_add_one: assert property (@(posedge mclk) disable iff (rst)
    (start && is_add_ptr && instr_word[7:6] == 2'h0)
    |=> ptr0 == $past(ptr0) + {6'h00, $past(instr_word[5:0])} && !busy)
    else $error("pointer add wrong");
  a_call_push: assert property (@(posedge mclk) disable iff (rst)
    (start && is_call_acc) |=> stack_push && pc_value[7:0] == $past(acc) ##1 !busy)
    else $error("call via accumulator wrong");
  a_ret_reload: assert property (@(posedge mclk) disable iff (rst)
    (start && is_add_ptr && instr_word[7:6] == 2'h3) |=> pc_load && pc_value == $past(return_stack_top))
    else $error("return reload wrong");
  a_push_dec: assert property (@(posedge mclk) disable iff (rst)
    (start && is_push_lit) |=> fdata_we && stack_frame_pointer == $past(stack_frame_pointer) - 12'h001)
    else $error("push literal wrong");
  a_move_to_file: assert property (@(posedge mclk) disable iff (rst)
    (start && is_move_idx && !instr_word[7] && next_word[15:12] == 4'hF)
    |=> fdata_we && fdata_waddr == $past(next_word[11:0]) ##1 !busy)
    else $error("move to file wrong");
  a_lone_second: assert property (@(posedge mclk) disable iff (rst)
    (start && instr_word[15:12] == 4'hF) |=> !fdata_we && !pc_load && !busy)
    else $error("lone second word acted");
endmodule : xsk_decode

// ===== inc/xsk_pkg.sv
// Opcodes, field positions, reset values and cycle counts of the decode block.
// Assumes a 16-bit instruction word and an 8-bit data path.
package xsk_pkg;
  localparam logic [7:0]  OP_XOR_LIT    = 8'h0A;
  localparam logic [5:0]  OP_XOR_FILE   = 6'h06;
  localparam logic [6:0]  OP_TEST_SKIP  = 7'h33;
  localparam logic [7:0]  OP_ADD_PTR    = 8'hE8;
  localparam logic [7:0]  OP_SUB_PTR    = 8'hE9;
  localparam logic [7:0]  OP_PUSH_LIT   = 8'hEA;
  localparam logic [7:0]  OP_MOVE_IDX   = 8'hEB;
  localparam logic [15:0] OP_CALL_ACC   = 16'h0014;
  localparam logic [3:0]  OP_SECOND     = 4'hF;
  localparam logic [1:0]  FRAME_SEL     = 2'h3;
  localparam logic [7:0]  INDEX_LIMIT   = 8'h5F;
  localparam int          DEST_BIT      = 9;
  localparam int          ACCESS_BIT    = 8;
  localparam int          MOVE_KIND_BIT = 7;
  localparam logic [1:0]  CYC_ONE       = 2'h1;
  localparam logic [1:0]  CYC_TWO       = 2'h2;
  localparam logic [1:0]  CYC_THREE     = 2'h3;
  localparam logic [7:0]  ACC_RESET     = 8'h00;
  localparam logic [11:0] PTR_RESET     = 12'h000;
  localparam logic [20:0] PC_RESET      = 21'h00_0000;
endpackage : xsk_pkg

// ===== hw/xsk_ptr_file.sv
// Three indirect pointers; pointer 2 is the stack frame pointer.
// Assumes one write per cycle from the decode block.
`timescale 1ns/100ps
module xsk_ptr_file #(
  parameter int W = 12
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         we,
  input  wire logic [1:0]   wsel,
  input  wire logic [W-1:0] wdata,
  output logic [W-1:0]      ptr0,
  output logic [W-1:0]      ptr1,
  output logic [W-1:0]      ptr2
);
  always_ff @(posedge mclk) begin
    if (rst) begin
      ptr0 <= xsk_pkg::PTR_RESET;
      ptr1 <= xsk_pkg::PTR_RESET;
      ptr2 <= xsk_pkg::PTR_RESET;
    end else if (we) begin
      case (wsel)
        2'h0:    ptr0 <= wdata;
        2'h1:    ptr1 <= wdata;
        default: ptr2 <= wdata;
      endcase
    end
  end
endmodule : xsk_ptr_file

// ===== bench/xsk_file_model.sv
// Behavioural data file that sits on the far side of the decode block.
// Assumes read data return combinationally for the read address, and writes land on the clock edge.
`timescale 1ns/100ps
module xsk_file_model (
  input  wire logic        mclk,
  input  wire logic [11:0] fdata_addr,
  output logic      [7:0]  fdata_rdata,
  input  wire logic        fdata_we,
  input  wire logic [11:0] fdata_waddr,
  input  wire logic [7:0]  fdata_wdata
);
  logic [7:0] mem [4096];
  // Every location whose low byte is 20h reads zero, so skip tests have a known target.
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i) ^ 8'h20;
    end
  end
  assign fdata_rdata = mem[fdata_addr];
  always @(posedge mclk) begin
    if (fdata_we === 1'b1) begin
      mem[fdata_waddr] <= fdata_wdata;
    end
  end
endmodule : xsk_file_model

// ===== bench/cpu_xor_skip_ext_decode_test.sv
// Self-checking testbench for the decode block, one task per scenario.
// Assumes the data file model answers reads combinationally; inputs change 1 ns after the rising edge.
`timescale 1ns/100ps
module cpu_xor_skip_ext_decode_test;
  logic mclk = 0, rst = 1, extension_enable_fuse = 0, instr_valid = 0;
  logic [15:0] instr_word = 0, next_word = 0;
  logic [7:0]  fdata_rdata, fdata_wdata, acc, counter_high_latch = 0, counter_upper_latch = 0;
  logic [3:0]  bank_select_pointer = 0;
  logic [20:0] return_stack_top = 0, pc_in = 0, pc_value, stack_push_value;
  logic [11:0] fdata_addr, fdata_waddr, ptr0, ptr1, stack_frame_pointer, seen_addr;
  logic        busy, fdata_we, flag_n, flag_z, pc_load, stack_push, stack_pop;
  int          bad_count = 0, total_checks = 0;
  xsk_decode xsk_decode_inst (.mclk(mclk), .rst(rst), .extension_enable_fuse(extension_enable_fuse),
    .instr_valid(instr_valid), .instr_word(instr_word), .next_word(next_word), .fdata_rdata(fdata_rdata),
    .bank_select_pointer(bank_select_pointer), .counter_high_latch(counter_high_latch),
    .counter_upper_latch(counter_upper_latch), .return_stack_top(return_stack_top), .pc_in(pc_in),
    .busy(busy), .fdata_addr(fdata_addr), .fdata_we(fdata_we), .fdata_waddr(fdata_waddr),
    .fdata_wdata(fdata_wdata), .acc(acc), .flag_n(flag_n), .flag_z(flag_z), .pc_load(pc_load),
    .pc_value(pc_value), .stack_push(stack_push), .stack_push_value(stack_push_value),
    .stack_pop(stack_pop), .ptr0(ptr0), .ptr1(ptr1), .stack_frame_pointer(stack_frame_pointer));
  xsk_file_model xsk_file_model_inst (.mclk(mclk), .fdata_addr(fdata_addr), .fdata_rdata(fdata_rdata),
    .fdata_we(fdata_we), .fdata_waddr(fdata_waddr), .fdata_wdata(fdata_wdata));
  always #25 mclk = ~mclk;
  task results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("ERROR at %0t: %s", $time, m);
    end
  endtask : chk
  // Leaves one idle edge so file writes land, then holds the word up to the taking edge.
  task issue(input logic [15:0] w, input logic [15:0] n);
    @(posedge mclk);
    #1 instr_valid = 1;
    instr_word = w;
    next_word = n;
    #1 seen_addr = fdata_addr;
    @(posedge mclk);
    #1 instr_valid = 0;
  endtask : issue
  task busy_len(input int n, input string m);
    int c;
    c = 0;
    while (busy === 1'b1 && c < 5) begin
      @(posedge mclk);
      #1 c++;
    end
    if (c == 5) begin
      bad_count++;
      results();
    end else begin
      chk(c == n, m);
    end
  endtask : busy_len
  task t_xor;
    issue(16'h0AB5, 0); chk(acc === 8'hB5 && flag_n === 1'b1 && flag_z === 1'b0, "xor literal");
    issue(16'h0AAF, 0); chk(acc === 8'h1A && flag_n === 1'b0 && flag_z === 1'b0, "xor walk");
    issue(16'h0A1A, 0); chk(acc === 8'h00 && flag_z === 1'b1, "xor zero flag");
    issue(16'h0AB5, 0);
    bank_select_pointer = 4'h3;
    issue(16'h1B21, 0); chk(seen_addr === 12'h321, "banked address");
    chk(fdata_we === 1'b1 && fdata_waddr === 12'h321 && fdata_wdata === 8'hB4, "xor to file");
    chk(acc === 8'hB5 && flag_n === 1'b1 && flag_z === 1'b0, "xor file flags");
    issue(16'h1921, 0); chk(acc === 8'h01 && fdata_we === 1'b0 && busy === 1'b0, "xor to acc");
    $display("test xor done");
  endtask : t_xor
  task t_skip;
    issue(16'h6722, 16'h0A00); busy_len(0, "no skip");
    issue(16'h6720, 16'h0A00); busy_len(1, "skip one word");
    issue(16'h6720, 16'hEB05); busy_len(1, "two-word head ignored with extension off");
    extension_enable_fuse = 1;
    issue(16'h6720, 16'hEB05); busy_len(2, "skip two words");
    extension_enable_fuse = 0;
    $display("test skip done");
  endtask : t_skip
  task t_ptr;
    issue(16'hE823, 0); chk(ptr0 === 12'h000, "fuse off ignored");
    extension_enable_fuse = 1;
    issue(16'hE823, 0); chk(ptr0 === 12'h023 && busy === 1'b0, "pointer add");
    issue(16'hE945, 0); chk(ptr1 === 12'hFFB && flag_z === 1'b0, "pointer sub");
    return_stack_top = 21'h01_2345;
    issue(16'hE8C5, 0); chk(stack_frame_pointer === 12'h005 && stack_pop === 1'b1, "frame add");
    chk(pc_load === 1'b1 && pc_value === 21'h01_2345, "frame return");
    busy_len(1, "frame add cycles");
    issue(16'hE9C1, 0); chk(stack_frame_pointer === 12'h004 && pc_load === 1'b1, "frame sub");
    busy_len(1, "frame sub cycles");
    $display("test pointer done");
  endtask : t_ptr
  task t_call;
    pc_in = 21'h00_1000;
    counter_high_latch = 8'h12;
    counter_upper_latch = 8'hE3;
    issue(16'h0014, 0); chk(stack_push === 1'b1 && stack_push_value === 21'h00_1002, "call push");
    chk(pc_load === 1'b1 && pc_value === 21'h03_1201 && flag_n === 1'b0, "call target");
    busy_len(1, "call cycles");
    $display("test call done");
  endtask : t_call
  task t_ext;
    issue(16'hEA77, 0); chk(fdata_we === 1'b1 && fdata_waddr === 12'h004 && fdata_wdata === 8'h77, "push");
    chk(stack_frame_pointer === 12'h003, "push decrement");
    issue(16'h1810, 0); chk(seen_addr === 12'h013, "indexed offset");
    issue(16'h1870, 0); chk(seen_addr === 12'h070, "direct above limit");
    extension_enable_fuse = 0;
    issue(16'h1810, 0); chk(seen_addr === 12'h010, "direct bank");
    extension_enable_fuse = 1;
    issue(16'hEB05, 16'hF123); chk(seen_addr === 12'h008, "move source");
    chk(fdata_we === 1'b1 && fdata_waddr === 12'h123 && fdata_wdata === 8'h28, "move to file");
    busy_len(1, "move cycles");
    issue(16'hEB85, 16'hF007); chk(seen_addr === 12'h008, "indexed move source");
    chk(fdata_we === 1'b1 && fdata_waddr === 12'h00A && fdata_wdata === 8'h28, "move to indexed");
    busy_len(1, "indexed move cycles");
    issue(16'hF123, 0); chk(fdata_we === 1'b0 && pc_load === 1'b0 && busy === 1'b0, "lone second word");
    $display("test extended done");
  endtask : t_ext
  initial begin
    repeat (8) @(posedge mclk);
    #1 rst = 0;
    t_xor();
    t_skip();
    t_ptr();
    t_call();
    t_ext();
    results();
  end
endmodule : cpu_xor_skip_ext_decode_test
